/* core/mpm_defs.svh */
`ifndef MPM_DEFS_SVH
`define MPM_DEFS_SVH
`define MPM_A_CFG 8'h00
`define MPM_A_SYNC 8'h04
`define MPM_A_PER0 8'h08
`define MPM_A_PER1 8'h0c
`define MPM_A_DUTY0 8'h10
`define MPM_A_DUTY1 8'h14
`define MPM_A_LLLO 8'h18
`define MPM_A_LLHI 8'h1c
`define MPM_A_OCLIM 8'h20
`define MPM_A_UCLIM 8'h24
`define MPM_A_CAL0 8'h28
`define MPM_A_STAT 8'h38
`define MPM_A_IOUT0 8'h3c
`define MPM_A_IOUT1 8'h40
`define MPM_A_ADJ 8'h44
`define MPM_CFG_N1 2:0
`define MPM_CFG_N2 5:3
`define MPM_CFG_SHED 6
`define MPM_CFG_LLCOEF 7
`define MPM_CFG_SHCNT 9:8
`define MPM_CFG_FSHUT 10
`define MPM_CFG_SRST 15
`define MPM_CFG_RST 16'h0001
`define MPM_SYNC_RST 16'hff00
`define MPM_PER_RST 16'h01f4
`define MPM_DUTY_RST 16'h0000
`define MPM_LIM_LO_RST 16'h0000
`define MPM_LIM_HI_RST 16'hffff
`define MPM_CAL_RST 32'h00001000
`define MPM_SYNC_SEL_MAX 8'h03
`define MPM_SPREAD_NUM 18'h00003
`define MPM_SPREAD_DEN 18'h0000d
`define MPM_BAL_STEP 8'h01
`define MPM_BANK_RAMP 2'h0
`define MPM_BANK_REG 2'h1
`define MPM_BANK_LIGHT 2'h2
`define MPM_GAIN_SH 12
`define MPM_FLT_SH 2
`define MPM_T_SAMPLE_US 200
`define MPM_CLK_MHZ 100
`endif

/* core/mpm_pkg.sv */
package mpm_pkg;
  typedef enum logic [0:0] {
    MPM_IDLE = 1'b0,
    MPM_WAIT = 1'b1
  } mpm_adc_st_t;
endpackage

/* core/mpm_stage_pwm.sv */
`timescale 1ns/1ps
module mpm_stage_pwm #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [W-1:0] cnt,
  input wire logic [W-1:0] per,
  input wire logic [W-1:0] off,
  input wire logic [W-1:0] thr,
  input wire logic en,
  output logic pwm,
  output logic start
);
  logic [W-1:0] ramp;
  logic pwm_d, start_d;

  always_comb begin
    ramp = (cnt >= off) ? W'(cnt - off) : W'(cnt + per - off);
    pwm_d = en && (ramp < thr);
    start_d = en && (ramp == '0);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm <= 1'b0;
      start <= 1'b0;
    end else if (clkEn) begin
      pwm <= pwm_d;
      start <= start_d;
    end
  end
endmodule

/* core/mpm_smooth.sv */
`timescale 1ns/1ps
module mpm_smooth #(
  parameter int W = 16,
  parameter int SH = 2
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [W-1:0] sample,
  output logic [W-1:0] avg
);
  logic signed [W:0] diff, sum;
  logic [W-1:0] avg_d;

  // Gain of one quarter gives a time constant near 3.5 samples
  always_comb begin
    diff = $signed({1'b0, sample}) - $signed({1'b0, avg});
    sum = $signed({1'b0, avg}) + (diff >>> SH);
    avg_d = load ? sum[W-1:0] : avg;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) avg <= '0;
    else if (clkEn) avg <= avg_d;
  end
endmodule

/* core/mpm_phase_mgr.sv */
`timescale 1ns/1ps
`include "mpm_defs.svh"
// Behaviour
// - One or two rails share up to four stages, each rail owns a count.
// - Splits 0:n and 1:3 are replaced by mirrored n:0 and 3:1.
// - Rail 2 starts three thirteenths of the faster period after rail 1.
// - Stage rising edges in a rail are spaced by period over stage count.
// - Sync word upper byte 0..3 picks the sync-out stage; else disabled.
// - Sync word lower byte is a rail mask of sync followers.
// - A rising sync input resets each following rail's period counter.
// - A late sync restart is not suppressed, even if it double pulses.
// - After an external sync edge with a following rail, rail spacing stays lost until soft reset.
// - With shedding on and current below low limit, stages are dropped.
// - Current above high limit re-adds all stages and normal bank.
// - All sense channels share one 12-bit converter in turn.
// - One active stage is sampled per 200 us tick, so each stage per N ticks for N active stages.
// - Each sample passes a first-order smoother of about 3.5 samples.
// - Rail current beyond over or under limit flags a fault and acts.
// - Each sample is scaled by its stage's own gain and offset.
// - Current readback is the sum of smoothed stage currents on a rail.
// - Multi-stage thresholds are base threshold plus stage adjustment.
// - Hottest stage adjustment moves to the coolest; never below zero.
// - Duty fraction times period forms the compare threshold.
// - Bank 0 in ramps, bank 2 at light load, bank 1 otherwise.
module mpm_phase_mgr
  import mpm_pkg::*;
#(
  parameter int SAMPLE_CYC = `MPM_T_SAMPLE_US * `MPM_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic syncIn,
  output logic syncOut,
  input wire logic [1:0] rampActive,
  output logic adcReq,
  output logic [1:0] adcChan,
  input wire logic adcValid,
  input wire logic [11:0] adcData,
  output logic [3:0] pwmOut,
  output logic [1:0][1:0] compBank
);
  localparam int TW = $clog2(SAMPLE_CYC + 1);

  logic [15:0] cfg_q, cfg_d, sync_q, sync_d;
  logic [15:0] llLo_q, llLo_d, llHi_q, llHi_d, oc_q, oc_d, uc_q, uc_d;
  logic [1:0][15:0] per_q, per_d, duty_q, duty_d, cnt_q, cnt_d;
  logic [3:0][31:0] cal_q, cal_d;
  logic [3:0][7:0] adj_q, adj_d;
  logic [3:0] flt_q, flt_d;
  logic [31:0] rdata_q, rdata_d;
  logic launch_q, launch_d, synced_q, synced_d;
  logic syncPrev_q, syncPrev_d, syncOut_q, syncOut_d;
  logic [1:0] shed_q, shed_d;
  logic [1:0][1:0] bank_q, bank_d;
  logic [TW-1:0] tmr_q, tmr_d;
  mpm_adc_st_t st_q, st_d;
  logic [1:0] chan_q, chan_d, nxt;
  logic adcReq_q, adcReq_d, convDone_q, convDone_d;

  logic [2:0] n1, n2, e1, e2;
  logic [1:0][2:0] nR, shc;
  logic [3:0] act, rl, shedOff, en, load, start;
  logic [3:0][1:0] idx;
  logic [1:0][15:0] step, thrB;
  logic [1:0][17:0] sumR;
  logic [1:0][31:0] dp;
  logic [3:0][15:0] off, thr, avg;
  logic [3:0][16:0] tsum;
  logic [15:0] pMin, spread, scaled;
  logic [17:0] spr, calS;
  logic [27:0] prod;
  logic [15:0] calV;
  logic [1:0] hiI, loI, cIdx;
  logic fnd, syncEdge, softRst, wEn, rdEn, bad, tick;

  // Effective stage split, invalid splits mirrored
  always_comb begin
    n1 = cfg_q[`MPM_CFG_N1];
    n2 = cfg_q[`MPM_CFG_N2];
    e1 = n1;
    e2 = n2;
    if (n1 == 3'h0) begin
      e1 = n2;
      e2 = 3'h0;
    end else if (n1 == 3'h1 && n2 == 3'h3) begin
      e1 = 3'h3;
      e2 = 3'h1;
    end
    nR[0] = e1;
    nR[1] = e2;
    // Fixed order 1A, 1B, 2A, 2B; rail 2 always starts at 2A
    act = 4'h0;
    rl = 4'h0;
    idx = '0;
    act[0] = e1 != 3'h0;
    act[1] = e1 >= 3'h2;
    idx[1] = 2'h1;
    if (e2 != 3'h0) begin
      act[2] = 1'b1;
      rl[2] = 1'b1;
    end else begin
      act[2] = e1 >= 3'h3;
      idx[2] = 2'h2;
    end
    if (e2 == 3'h2) begin
      act[3] = 1'b1;
      rl[3] = 1'b1;
      idx[3] = 2'h1;
    end else if (e2 == 3'h1) begin
      act[3] = e1 == 3'h3;
      idx[3] = 2'h2;
    end else begin
      act[3] = e1 == 3'h4;
      idx[3] = 2'h3;
    end
  end

  // Per-rail spacing, threshold, current sum
  always_comb begin
    for (int r = 0; r < 2; r++) begin
      unique case (nR[r])
        3'h2: step[r] = per_q[r] >> 1;
        3'h3: step[r] = per_q[r] / 16'h0003;
        3'h4: step[r] = per_q[r] >> 2;
        default: step[r] = 16'h0000;
      endcase
      dp[r] = duty_q[r] * per_q[r];
      thrB[r] = dp[r][31:16];
      shc[r] = (nR[r] == 3'h0) ? 3'h0 :
        ({1'b0, cfg_q[`MPM_CFG_SHCNT]} >= nR[r]) ? 3'(nR[r] - 3'h1) :
        {1'b0, cfg_q[`MPM_CFG_SHCNT]};
      sumR[r] = 18'h00000;
      for (int s = 0; s < 4; s++)
        if (act[s] && rl[s] == r[0]) sumR[r] = sumR[r] + 18'(avg[s]);
    end
    for (int s = 0; s < 4; s++) begin
      off[s] = 16'(step[rl[s]] * 16'(idx[s]));
      tsum[s] = 17'(thrB[rl[s]]);
      if (nR[rl[s]] > 3'h1) tsum[s] = tsum[s] + 17'(adj_q[s]);
      thr[s] = tsum[s][16] ? 16'hffff : tsum[s][15:0];
      shedOff[s] = shed_q[rl[s]] &&
        (3'(idx[s]) >= 3'(nR[rl[s]] - shc[rl[s]]));
      en[s] = act[s] && !shedOff[s] && !(cfg_q[`MPM_CFG_FSHUT] &&
        (flt_q[rl[s]] || flt_q[2 + 32'(rl[s])]));
    end
    pMin = (per_q[1] < per_q[0] && nR[1] != 3'h0) ? per_q[1] : per_q[0];
    spr = (18'(pMin) * `MPM_SPREAD_NUM) / `MPM_SPREAD_DEN;
    spread = spr[15:0];
  end

  // Calibration of the converter word
  always_comb begin
    prod = adcData * cal_q[chan_q][15:0];
    scaled = prod[27:12];
    calS = {2'h0, scaled} + {{2{cal_q[chan_q][31]}}, cal_q[chan_q][31:16]};
    if (calS[17]) calV = 16'h0000;
    else if (calS[16]) calV = 16'hffff;
    else calV = calS[15:0];
  end

  genvar gs;
  generate
    for (gs = 0; gs < 4; gs++) begin : g_stage
      mpm_stage_pwm #(.W(16)) u_pwm (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .cnt(cnt_q[rl[gs]]),
        .per(per_q[rl[gs]]),
        .off(off[gs]),
        .thr(thr[gs]),
        .en(en[gs]),
        .pwm(pwmOut[gs]),
        .start(start[gs])
      );
      mpm_smooth #(.W(16), .SH(`MPM_FLT_SH)) u_avg (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .load(load[gs]),
        .sample(calV),
        .avg(avg[gs])
      );
    end
  endgenerate

  assign pready = clkEn;
  assign pslverr = psel && penable && bad;
  assign prdata = rdata_q;
  assign syncOut = syncOut_q;
  assign adcReq = adcReq_q;
  assign adcChan = chan_q;
  assign compBank = bank_q;

  always_comb begin
    cfg_d = cfg_q;
    sync_d = sync_q;
    llLo_d = llLo_q;
    llHi_d = llHi_q;
    oc_d = oc_q;
    uc_d = uc_q;
    per_d = per_q;
    duty_d = duty_q;
    cal_d = cal_q;
    adj_d = adj_q;
    rdata_d = rdata_q;
    cIdx = 2'(paddr[5:2] - 4'ha);
    bad = paddr[1:0] != 2'h0 || paddr > `MPM_A_ADJ;
    wEn = psel && penable && pwrite && !bad;
    rdEn = psel && !penable && !pwrite;
    softRst = wEn && paddr == `MPM_A_CFG && pwdata[`MPM_CFG_SRST];
    if (wEn) begin
      unique case (paddr)
        `MPM_A_CFG: cfg_d = {1'b0, pwdata[14:0]};
        `MPM_A_SYNC: sync_d = pwdata[15:0];
        `MPM_A_PER0: per_d[0] = pwdata[15:0];
        `MPM_A_PER1: per_d[1] = pwdata[15:0];
        `MPM_A_DUTY0: duty_d[0] = pwdata[15:0];
        `MPM_A_DUTY1: duty_d[1] = pwdata[15:0];
        `MPM_A_LLLO: llLo_d = pwdata[15:0];
        `MPM_A_LLHI: llHi_d = pwdata[15:0];
        `MPM_A_OCLIM: oc_d = pwdata[15:0];
        `MPM_A_UCLIM: uc_d = pwdata[15:0];
        default: begin
          if (paddr >= `MPM_A_CAL0 && paddr < `MPM_A_STAT)
            cal_d[cIdx] = pwdata;
        end
      endcase
    end
    if (rdEn) begin
      rdata_d = 32'h00000000;
      unique case (paddr)
        `MPM_A_CFG: rdata_d[15:0] = cfg_q;
        `MPM_A_SYNC: rdata_d[15:0] = sync_q;
        `MPM_A_PER0: rdata_d[15:0] = per_q[0];
        `MPM_A_PER1: rdata_d[15:0] = per_q[1];
        `MPM_A_DUTY0: rdata_d[15:0] = duty_q[0];
        `MPM_A_DUTY1: rdata_d[15:0] = duty_q[1];
        `MPM_A_LLLO: rdata_d[15:0] = llLo_q;
        `MPM_A_LLHI: rdata_d[15:0] = llHi_q;
        `MPM_A_OCLIM: rdata_d[15:0] = oc_q;
        `MPM_A_UCLIM: rdata_d[15:0] = uc_q;
        `MPM_A_STAT: rdata_d[21:0] = {e2, e1, en, bank_q[1], bank_q[0],
          shed_q, synced_q, launch_q, flt_q};
        `MPM_A_IOUT0: rdata_d[17:0] = sumR[0];
        `MPM_A_IOUT1: rdata_d[17:0] = sumR[1];
        `MPM_A_ADJ: rdata_d = adj_q;
        default: begin
          if (paddr >= `MPM_A_CAL0 && paddr < `MPM_A_STAT)
            rdata_d = cal_q[cIdx];
        end
      endcase
    end
    // Current balancing; a saturated low side skips the move
    for (int r = 0; r < 2; r++) begin
      hiI = 2'h0;
      loI = 2'h0;
      fnd = 1'b0;
      for (int s = 0; s < 4; s++) begin
        if (act[s] && rl[s] == r[0] && !shedOff[s]) begin
          if (!fnd || avg[s] > avg[hiI]) hiI = 2'(s);
          if (!fnd || avg[s] < avg[loI]) loI = 2'(s);
          fnd = 1'b1;
        end
      end
      if (convDone_q && nR[r] > 3'h1 && hiI != loI &&
          adj_q[loI] <= 8'hff - `MPM_BAL_STEP) begin
        adj_d[loI] = adj_q[loI] + `MPM_BAL_STEP;
        if (adj_q[hiI] >= `MPM_BAL_STEP)
          adj_d[hiI] = adj_q[hiI] - `MPM_BAL_STEP;
      end
    end
    if (softRst) adj_d = '0;
  end

  // Period counters, sync, spacing
  always_comb begin
    syncPrev_d = syncIn;
    syncEdge = syncIn && !syncPrev_q;
    synced_d = synced_q || (syncEdge && |sync_q[1:0]);
    launch_d = launch_q || cnt_q[0] == spread || synced_q;
    for (int r = 0; r < 2; r++) begin
      cnt_d[r] = (17'(cnt_q[r]) + 17'h00001 >= 17'(per_q[r])) ?
        16'h0000 : 16'(cnt_q[r] + 16'h0001);
      if (r == 1 && !launch_d) cnt_d[r] = 16'h0000;
      // No check of pulse state: a late edge may double pulse
      if (syncEdge && sync_q[r]) cnt_d[r] = 16'h0000;
    end
    if (softRst) begin
      synced_d = 1'b0;
      launch_d = 1'b0;
      cnt_d = '0;
    end
    syncOut_d = sync_q[15:8] <= `MPM_SYNC_SEL_MAX &&
      start[sync_q[9:8]];
  end

  // Sampling, shedding, faults, banks
  always_comb begin
    tick = tmr_q == TW'(SAMPLE_CYC - 1);
    tmr_d = tick ? '0 : TW'(tmr_q + 1'b1);
    st_d = st_q;
    chan_d = chan_q;
    adcReq_d = 1'b0;
    load = 4'h0;
    nxt = chan_q;
    for (int k = 4; k > 0; k--)
      if (act[2'(chan_q + 2'(k))]) nxt = 2'(chan_q + 2'(k));
    unique case (st_q)
      MPM_IDLE: begin
        if (tick && |act) begin
          st_d = MPM_WAIT;
          chan_d = nxt;
          adcReq_d = 1'b1;
        end
      end
      MPM_WAIT: begin
        if (adcValid) begin
          st_d = MPM_IDLE;
          load[chan_q] = 1'b1;
        end
      end
    endcase
    convDone_d = |load;
    flt_d = flt_q;
    if (wEn && paddr == `MPM_A_STAT) flt_d = flt_q & ~pwdata[3:0];
    for (int r = 0; r < 2; r++) begin
      if (nR[r] != 3'h0 && sumR[r] > 18'(oc_q)) flt_d[r] = 1'b1;
      if (nR[r] != 3'h0 && sumR[r] < 18'(uc_q)) flt_d[r+2] = 1'b1;
      if (shed_q[r]) shed_d[r] = !(sumR[r] > 18'(llHi_q));
      else shed_d[r] = cfg_q[`MPM_CFG_SHED] && nR[r] > 3'h1 &&
        sumR[r] < 18'(llLo_q);
      if (rampActive[r]) bank_d[r] = `MPM_BANK_RAMP;
      else if (shed_q[r] && cfg_q[`MPM_CFG_LLCOEF])
        bank_d[r] = `MPM_BANK_LIGHT;
      else bank_d[r] = `MPM_BANK_REG;
    end
    if (softRst) shed_d = 2'h0;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= `MPM_CFG_RST;
      sync_q <= `MPM_SYNC_RST;
      llLo_q <= `MPM_LIM_LO_RST;
      llHi_q <= `MPM_LIM_LO_RST;
      oc_q <= `MPM_LIM_HI_RST;
      uc_q <= `MPM_LIM_LO_RST;
      per_q <= {2{`MPM_PER_RST}};
      duty_q <= {2{`MPM_DUTY_RST}};
      cal_q <= {4{`MPM_CAL_RST}};
      adj_q <= '0;
      flt_q <= 4'h0;
      rdata_q <= 32'h00000000;
      cnt_q <= '0;
      launch_q <= 1'b0;
      synced_q <= 1'b0;
      syncPrev_q <= 1'b0;
      syncOut_q <= 1'b0;
      shed_q <= 2'h0;
      bank_q <= {2{`MPM_BANK_RAMP}};
      tmr_q <= '0;
      st_q <= MPM_IDLE;
      chan_q <= 2'h0;
      adcReq_q <= 1'b0;
      convDone_q <= 1'b0;
    end else if (clkEn) begin
      cfg_q <= cfg_d;
      sync_q <= sync_d;
      llLo_q <= llLo_d;
      llHi_q <= llHi_d;
      oc_q <= oc_d;
      uc_q <= uc_d;
      per_q <= per_d;
      duty_q <= duty_d;
      cal_q <= cal_d;
      adj_q <= adj_d;
      flt_q <= flt_d;
      rdata_q <= rdata_d;
      cnt_q <= cnt_d;
      launch_q <= launch_d;
      synced_q <= synced_d;
      syncPrev_q <= syncPrev_d;
      syncOut_q <= syncOut_d;
      shed_q <= shed_d;
      bank_q <= bank_d;
      tmr_q <= tmr_d;
      st_q <= st_d;
      chan_q <= chan_d;
      adcReq_q <= adcReq_d;
      convDone_q <= convDone_d;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_split_mirror: assert property (n1 == 3'h0 && n2 != 3'h0 |->
    e1 == n2 && e2 == 3'h0) else $error("zero split not mirrored");
  a_sync_reset: assert property (clkEn && syncEdge && sync_q[0]
    && !softRst |=> cnt_q[0] == 16'h0000) else $error("no sync reset");
  a_sync_off: assert property (clkEn && sync_q[15:8] > 8'h03
    |=> !syncOut) else $error("sync out not disabled");
  a_spacing_lost: assert property (synced_q && !(clkEn && softRst)
    |=> synced_q) else $error("spacing restored without reset");
  a_shed_entry: assert property (clkEn && !shed_q[0] && cfg_q[6]
    && e1 > 3'h1 && sumR[0] < 18'(llLo_q) && !softRst |=> shed_q[0])
    else $error("shed not entered");
  a_shed_exit: assert property (clkEn && shed_q[0]
    && sumR[0] > 18'(llHi_q) |=> !shed_q[0]) else $error("shed kept");
  a_oc_fault: assert property (clkEn && e1 != 3'h0
    && sumR[0] > 18'(oc_q) |=> flt_q[0]) else $error("oc not flagged");
  a_req_spacing: assert property (adcReq |=> !adcReq [*4])
    else $error("converter requests too close");
  a_bank_light: assert property (clkEn && shed_q[0] && cfg_q[7]
    && !rampActive[0] |=> compBank[0] == 2'h2) else $error("bank wrong");

  c_sync_follow: cover property (syncEdge && sync_q[0]);
  c_shed_in: cover property (!shed_q[0] ##1 shed_q[0]);
  c_fault: cover property (!flt_q[0] ##1 flt_q[0]);
  c_sync_out: cover property (syncOut);
endmodule

/* sim/mpm_adc_model.sv */
`timescale 1ns/1ps
module mpm_adc_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic adcReq,
  input wire logic [1:0] adcChan,
  input wire logic [3:0][11:0] chanData,
  input wire logic [31:0] lat,
  output logic adcValid,
  output logic [11:0] adcData
);
  logic [1:0] ch;
  int n;
  // One conversion at a time, any channel, after lat cycles
  initial begin
    adcValid = 1'b0;
    adcData = 12'h000;
    forever begin
      @(posedge sys_clk);
      if (adcReq === 1'b1) begin
        ch = adcChan;
        n = 0;
        // Lat is read every cycle, so a held request can be let go later
        while (n < lat && arst_n === 1'b1) begin
          @(posedge sys_clk);
          n++;
        end
        if (arst_n === 1'b1) begin
          adcValid <= 1'b1;
          adcData <= chanData[ch];
          @(posedge sys_clk);
          adcValid <= 1'b0;
          // Data bus floats after the strobe; show the inverse, not a copy
          adcData <= ~chanData[ch];
        end
      end
    end
  end
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
`include "mpm_defs.svh"
module tb;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic syncIn, syncOut, adcReq, adcValid, syncRun;
  logic clkEn = 1'b1;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] rampActive, adcChan, c1, c2;
  logic [11:0] adcData;
  logic [3:0] pwmOut;
  logic [1:0][1:0] compBank;
  logic [3:0][11:0] chanData;
  logic [4:0] outs;
  int adcLat, errTotal, totalChecks, a, b, c;
  int cyc = 0;
  int sCnt = 0;
  int sPer = 30;
  assign outs = {syncOut, pwmOut};
  mpm_phase_mgr #(.SAMPLE_CYC(16)) mpm_phase_mgr_i (.sys_clk(sys_clk),
    .arst_n(arst_n), .clkEn(clkEn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .syncIn(syncIn), .syncOut(syncOut),
    .rampActive(rampActive), .adcReq(adcReq), .adcChan(adcChan),
    .adcValid(adcValid), .adcData(adcData), .pwmOut(pwmOut),
    .compBank(compBank));
  mpm_adc_model mpm_adc_model_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .adcReq(adcReq), .adcChan(adcChan), .chanData(chanData), .lat(adcLat),
    .adcValid(adcValid), .adcData(adcData));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Peer sync source; the >= tolerates a shorter period set mid-count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (syncRun) begin
      sCnt <= (sCnt >= sPer - 1) ? 0 : sCnt + 1;
      syncIn <= (sCnt < 3);
    end else begin
      syncIn <= 1'b0;
    end
    if (cyc == 60000) begin
      errTotal++;
      $display("mismatch t=%0t run too long", $time);
      completeRun();
    end
  end
  task automatic completeRun();
    $display("checks %0d errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp,
                        input string msg);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chkCyc(input int got, input int exp, input string msg);
    totalChecks++;
    if (got != exp) begin
      errTotal++;
      $display("mismatch t=%0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask
  function automatic int md(input int x, input int m);
    return ((x % m) + m) % m;
  endfunction
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] rd_v, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No limit here; pready high or else the bench timeout ends this wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, ad, d, x, e);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] x);
    logic e;
    apb(1'b0, ad, 32'h0, x, e);
  endtask
  task automatic rst();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
  endtask
  task automatic rise(input int i, output int t);
    int n;
    logic p;
    p = outs[i];
    t = -1;
    n = 0;
    while (n < 500 && t < 0) begin
      @(posedge sys_clk);
      n++;
      if (outs[i] === 1'b1 && p === 1'b0) t = cyc;
      p = outs[i];
    end
  endtask
  task automatic reqAt(output int t, output logic [1:0] ch);
    int n;
    t = -1;
    n = 0;
    while (n < 200 && t < 0) begin
      @(posedge sys_clk);
      n++;
      if (adcReq === 1'b1) begin
        t = cyc;
        ch = adcChan;
      end
    end
  endtask
  task automatic waitConv(input int k);
    int n, c0;
    n = 0;
    c0 = 0;
    while (n < k && c0 < 2000) begin
      @(posedge sys_clk);
      c0++;
      if (adcValid === 1'b1) n++;
    end
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic tRegs();
    logic e;
    rd(`MPM_A_CFG, r);
    chkVal(r, 32'h00000001, "cfg rst");
    rd(`MPM_A_SYNC, r);
    chkVal(r, 32'h0000ff00, "sync rst");
    rd(`MPM_A_PER0, r);
    chkVal(r, 32'h000001f4, "per rst");
    rd(`MPM_A_OCLIM, r);
    chkVal(r, 32'h0000ffff, "oc rst");
    apb(1'b0, 8'h48, 32'h0, r, e);
    chkVal(r, 32'h00000000, "unmapped data");
    chkVal(e, 1'b1, "unmapped error");
  endtask
  task automatic tSplit();
    logic [5:0] cf[4] = '{6'h10, 6'h19, 6'h12, 6'h20};
    logic [5:0] ex[4] = '{6'h02, 6'h0b, 6'h12, 6'h04};
    for (int i = 0; i < 4; i++) begin
      wr(`MPM_A_CFG, {26'h0, cf[i]});
      rd(`MPM_A_STAT, r);
      chkVal(r[21:16], ex[i], "split");
    end
  endtask
  task automatic tPhase();
    int t0, n, t;
    rst();
    wr(`MPM_A_PER0, 32'h00000028);
    wr(`MPM_A_DUTY0, 32'h00004000);
    wr(`MPM_A_CFG, 32'h00000004);
    rise(0, t0);
    n = 1;
    @(posedge sys_clk);
    while (outs[0] === 1'b1 && n < 100) begin
      n++;
      @(posedge sys_clk);
    end
    chkCyc(n, 10, "width");
    for (int i = 1; i < 4; i++) begin
      rise(i, t);
      chkCyc(md(t - t0, 40), 10 * i, "phase step");
    end
    // Enable low must freeze pulses and stall the bus
    clkEn <= 1'b0;
    @(posedge sys_clk);
    r[4:0] = outs;
    repeat (20) @(posedge sys_clk);
    chkVal({pready, outs}, {1'b0, r[4:0]}, "frozen");
    clkEn <= 1'b1;
  endtask
  task automatic tSpread();
    rst();
    wr(`MPM_A_PER0, 32'h00000027);
    wr(`MPM_A_PER1, 32'h00000027);
    wr(`MPM_A_DUTY0, 32'h00004000);
    wr(`MPM_A_DUTY1, 32'h00004000);
    wr(`MPM_A_CFG, 32'h00000009);
    rise(0, a);
    rise(2, b);
    chkCyc(md(b - a, 39), 9, "rail spread");
  endtask
  task automatic tSyncOut();
    rst();
    wr(`MPM_A_PER0, 32'h00000028);
    wr(`MPM_A_DUTY0, 32'h00004000);
    wr(`MPM_A_CFG, 32'h00000004);
    for (int s = 0; s < 5; s++) begin
      wr(`MPM_A_SYNC, s << 8);
      if (s < 4) begin
        rise(s, a);
        rise(4, b);
        chkCyc(md(b - a, 40), 1, "sync out");
      end else begin
        rise(4, b);
        chkCyc(b, -1, "sync out off");
      end
    end
  endtask
  task automatic tSyncIn();
    rst();
    wr(`MPM_A_PER0, 32'h00000028);
    wr(`MPM_A_PER1, 32'h00000028);
    wr(`MPM_A_DUTY0, 32'h00004000);
    wr(`MPM_A_DUTY1, 32'h00004000);
    wr(`MPM_A_CFG, 32'h00000009);
    wr(`MPM_A_SYNC, 32'h0000ff01);
    sPer = 60;
    syncRun = 1'b1;
    repeat (130) @(posedge sys_clk);
    rise(0, a);
    rise(0, b);
    rise(0, c);
    chkCyc(c - a, 60, "double pulse");
    sPer = 30;
    repeat (70) @(posedge sys_clk);
    rise(0, a);
    rise(0, b);
    chkCyc(b - a, 30, "follow");
    rise(2, a);
    rise(2, b);
    chkCyc(b - a, 40, "not follow");
    rd(`MPM_A_STAT, r);
    chkVal(r[5], 1'b1, "synced");
    wr(`MPM_A_SYNC, 32'h0000ff03);
    repeat (70) @(posedge sys_clk);
    rise(2, a);
    rise(2, b);
    chkCyc(b - a, 30, "both follow");
    syncRun = 1'b0;
    wr(`MPM_A_CFG, 32'h00008009);
    rd(`MPM_A_STAT, r);
    chkVal(r[5], 1'b0, "soft reset");
  endtask
  task automatic tAdc();
    rst();
    wr(`MPM_A_CAL0 + 8'h04, 32'h00002000);
    wr(`MPM_A_OCLIM, 32'h00000014);
    wr(`MPM_A_CFG, 32'h00000002);
    chanData[0] = 12'h064;
    chanData[1] = 12'h0c8;
    adcLat = 2;
    waitConv(2);
    // 100 -> 25 and 2.0 * 200 -> 100 after one smoothing step each
    rd(`MPM_A_IOUT0, r);
    chkVal(r, 32'h0000007d, "iout sum");
    rd(`MPM_A_ADJ, r);
    // Stage 1A was lowest after both steps, 1B stays at zero
    chkVal(r, 32'h00000002, "balance");
    rd(`MPM_A_STAT, r);
    chkVal(r[0], 1'b1, "oc fault");
    reqAt(a, c1);
    reqAt(b, c2);
    chkCyc(b - a, 16, "sample tick");
    chkVal(c1 ^ c2, 2'h1, "round robin");
  endtask
  task automatic tShed();
    chanData = '0;
    rst();
    wr(`MPM_A_LLLO, 32'h00000100);
    wr(`MPM_A_CFG, 32'h000001c2);
    waitConv(3);
    chkVal(compBank[0], 2'h2, "light bank");
    rd(`MPM_A_STAT, r);
    chkVal(r[15:12], 4'h1, "shed");
    wr(`MPM_A_LLLO, 32'h00000000);
    wr(`MPM_A_LLHI, 32'h00000010);
    chanData[0] = 12'h190;
    waitConv(2);
    chkVal(compBank[0], 2'h1, "normal bank");
    rd(`MPM_A_STAT, r);
    chkVal(r[15:12], 4'h3, "re-add");
    rampActive <= 2'b01;
    repeat (3) @(posedge sys_clk);
    chkVal(compBank[0], 2'h0, "ramp bank");
    rampActive <= 2'b00;
  endtask
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    syncIn = 1'b0;
    syncRun = 1'b0;
    rampActive = 2'b00;
    chanData = '0;
    // Converter held busy so pulse widths see no balance trim
    adcLat = 100000;
    errTotal = 0;
    totalChecks = 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    tRegs();
    tSplit();
    tPhase();
    tSpread();
    tSyncOut();
    tSyncIn();
    tAdc();
    tShed();
    completeRun();
  end
endmodule
